// ===== design/rpems_evt_if.sv
// Purpose: Carries the merged per-class error flags and arbitrated IDs from the selector to the status file
// Assumes: Single clock domain
// Notes:   Plain wires, no clocking
`timescale 1ns/100ps
`default_nettype none
interface rpems_evt_if;
	import rpems_pkg::*;
	logic             cor;
	logic             nonfatal;
	logic             fatal;
	logic [RID_W-1:0] cor_rid;
	logic [RID_W-1:0] unc_rid;
	modport src (output cor, nonfatal, fatal, cor_rid, unc_rid);
	modport dst (input  cor, nonfatal, fatal, cor_rid, unc_rid);
endinterface
`default_nettype wire

// ===== design/rpems_evt_sel.sv
// Purpose: Merges link-received and internal error events, picks the logged ID
// Assumes: Each source gives at most one event per clock
// Notes:   Purely combinational
`timescale 1ns/100ps
`default_nettype none
module rpems_evt_sel (
	// Link-received error message
	input  wire logic                        i_lnk_vld,
	input  wire rpems_pkg::rpems_sev_t       i_lnk_sev,
	input  wire logic [rpems_pkg::RID_W-1:0] i_lnk_rid,
	// Internally detected error
	input  wire logic                        i_int_vld,
	input  wire rpems_pkg::rpems_sev_t       i_int_sev,
	input  wire logic [rpems_pkg::RID_W-1:0] i_int_rid,
	// Merged event
	rpems_evt_if.src                         evt
);
	import rpems_pkg::*;

	function automatic logic is_sev(input logic v, input rpems_sev_t s, input rpems_sev_t w);
		is_sev = v && (s == w);
	endfunction

	logic lnk_unc;

	always_comb begin
		lnk_unc      = is_sev(i_lnk_vld, i_lnk_sev, RPEMS_SEV_NONFATAL) ||
		               is_sev(i_lnk_vld, i_lnk_sev, RPEMS_SEV_FATAL);
		evt.cor      = is_sev(i_lnk_vld, i_lnk_sev, RPEMS_SEV_COR) ||
		               is_sev(i_int_vld, i_int_sev, RPEMS_SEV_COR);
		evt.nonfatal = is_sev(i_lnk_vld, i_lnk_sev, RPEMS_SEV_NONFATAL) ||
		               is_sev(i_int_vld, i_int_sev, RPEMS_SEV_NONFATAL);
		evt.fatal    = is_sev(i_lnk_vld, i_lnk_sev, RPEMS_SEV_FATAL) ||
		               is_sev(i_int_vld, i_int_sev, RPEMS_SEV_FATAL);
		// Link wins when both arrive together
		evt.cor_rid  = is_sev(i_lnk_vld, i_lnk_sev, RPEMS_SEV_COR) ? i_lnk_rid : i_int_rid;
		evt.unc_rid  = lnk_unc ? i_lnk_rid : i_int_rid;
	end
endmodule // rpems_evt_sel
`default_nettype wire

// ===== design/rpems_pkg.sv
// Purpose: Shared constants and types for the root port error message status block
// Assumes: 32-bit register port, byte offsets as printed
// Notes:   Status bit positions and field layouts live here only
package rpems_pkg;
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned RID_W  = 16;

	localparam logic [11:0] OFS_INT_CTRL   = 12'h012C;
	localparam logic [11:0] OFS_MSG_STATUS = 12'h0130;
	localparam logic [11:0] OFS_SRC_ID     = 12'h0134;

	localparam int unsigned BIT_COR_FIRST   = 0;
	localparam int unsigned BIT_COR_MULTI   = 1;
	localparam int unsigned BIT_UNC_FIRST   = 2;
	localparam int unsigned BIT_UNC_MULTI   = 3;
	localparam int unsigned BIT_FIRST_FATAL = 4;
	localparam int unsigned BIT_NONFATAL    = 5;
	localparam int unsigned BIT_FATAL       = 6;
	localparam int unsigned FLAG_W          = 7;

	localparam int unsigned MSGNUM_LSB = 27;
	localparam int unsigned MSGNUM_W   = 5;

	localparam int unsigned SRC_UNC_LSB = 16;
	localparam int unsigned SRC_COR_LSB = 0;

	localparam int unsigned EN_COR   = 0;
	localparam int unsigned EN_NONF  = 1;
	localparam int unsigned EN_FATAL = 2;
	localparam int unsigned EN_W     = 3;

	localparam logic [6:0]  FLAGS_RST  = 7'h00;
	localparam logic [15:0] RID_RST    = 16'h0000;
	localparam logic [31:0] DATA_ZERO  = 32'h0000_0000;
	localparam logic [2:0]  EN_RST     = 3'h0;

	// Severity of one error event
	typedef enum logic [1:0] {
		RPEMS_SEV_COR,
		RPEMS_SEV_NONFATAL,
		RPEMS_SEV_FATAL,
		RPEMS_SEV_NONE
	} rpems_sev_t;
endpackage

// ===== design/rpems_src_log.sv
// Purpose: Holds the first-error source IDs for both classes
// Assumes: Capture strobes come from the status file
// Notes:   Sticky; only power-on clears, never i_rst_n
`timescale 1ns/100ps
`default_nettype none
module rpems_src_log (
	// Clock
	input  wire logic                         i_clk,
	// Power-on clear
	input  wire logic                         i_por,
	// Capture
	input  wire logic                         i_cap_cor,
	input  wire logic                         i_cap_unc,
	rpems_evt_if.dst                          evt,
	// Logged IDs
	output logic      [rpems_pkg::DATA_W-1:0] o_src_id
);
	import rpems_pkg::*;

	logic [RID_W-1:0] cor_q, cor_d, unc_q, unc_d;

	always_comb begin
		cor_d = cor_q;
		unc_d = unc_q;
		if (i_por) begin
			cor_d = RID_RST;
			unc_d = RID_RST;
		end else begin
			if (i_cap_cor) cor_d = evt.cor_rid;
			if (i_cap_unc) unc_d = evt.unc_rid;
		end
	end

	always_ff @(posedge i_clk) begin
		cor_q <= cor_d;
		unc_q <= unc_d;
	end

	assign o_src_id = {unc_q, cor_q};
endmodule // rpems_src_log
`default_nettype wire

// ===== design/rpems_top.sv
// Purpose: Root port error message status register bank with source ID log
// Assumes: Register port with read data one cycle after the read strobe
// Notes:   Status, enables and IDs survive i_rst_n; only i_por clears them
`timescale 1ns/100ps
`default_nettype none
module rpems_top #(
	parameter logic [4:0] MSG_NUM = 5'h00
) (
	// Clock and resets
	input  wire logic                          i_clk,
	input  wire logic                          i_rst_n,
	input  wire logic                          i_por,
	// Register port
	input  wire logic [rpems_pkg::ADDR_W-1:0]  i_addr,
	input  wire logic [rpems_pkg::DATA_W-1:0]  i_wdata,
	input  wire logic                          i_wr,
	input  wire logic                          i_rd,
	output logic      [rpems_pkg::DATA_W-1:0]  o_rdata,
	// Link-received error message
	input  wire logic                          i_lnk_vld,
	input  wire rpems_pkg::rpems_sev_t         i_lnk_sev,
	input  wire logic [rpems_pkg::RID_W-1:0]   i_lnk_rid,
	// Internally detected error
	input  wire logic                          i_int_vld,
	input  wire rpems_pkg::rpems_sev_t         i_int_sev,
	input  wire logic [rpems_pkg::RID_W-1:0]   i_int_rid,
	// Escalation and interrupt requests
	output logic                               o_fatal_esc,
	output logic                               o_nonfatal_esc,
	output logic                               o_irq_fatal,
	output logic                               o_irq_nonfatal,
	output logic                               o_irq_cor
);
	import rpems_pkg::*;

	rpems_evt_if evt ();

	logic [FLAG_W-1:0] flags_q, flags_d;
	logic [EN_W-1:0]   en_q, en_d;
	logic [DATA_W-1:0] rdata_q, rdata_d;
	logic [DATA_W-1:0] src_id;
	logic [FLAG_W-1:0] set_v, clr_v;
	logic              wr_sts, cap_cor, cap_unc, any_unc, both_unc;

	rpems_evt_sel u_sel (
		.i_lnk_vld (i_lnk_vld),
		.i_lnk_sev (i_lnk_sev),
		.i_lnk_rid (i_lnk_rid),
		.i_int_vld (i_int_vld),
		.i_int_sev (i_int_sev),
		.i_int_rid (i_int_rid),
		.evt       (evt)
	);

	rpems_src_log u_log (
		.i_clk     (i_clk),
		.i_por     (i_por),
		.i_cap_cor (cap_cor),
		.i_cap_unc (cap_unc),
		.evt       (evt),
		.o_src_id  (src_id)
	);

	// Event set terms
	always_comb begin
		any_unc  = evt.fatal || evt.nonfatal;
		both_unc = evt.fatal && evt.nonfatal;
		// Capture only when the first flag is clear going in
		cap_cor  = evt.cor && !flags_q[BIT_COR_FIRST];
		cap_unc  = any_unc && !flags_q[BIT_UNC_FIRST];
		set_v    = '0;
		set_v[BIT_COR_FIRST] = evt.cor;
		set_v[BIT_COR_MULTI] = evt.cor && flags_q[BIT_COR_FIRST];
		set_v[BIT_UNC_FIRST] = any_unc;
		set_v[BIT_UNC_MULTI] = any_unc && flags_q[BIT_UNC_FIRST];
		set_v[BIT_NONFATAL]  = evt.nonfatal;
		set_v[BIT_FATAL]     = evt.fatal;
		// Same-clock fatal and non-fatal: fatal taken as first severity
		set_v[BIT_FIRST_FATAL] = cap_unc && evt.fatal;
		if (both_unc) set_v[BIT_FIRST_FATAL] = cap_unc;
	end

	// Status flags and enables; i_rst_n deliberately not used here
	always_comb begin
		wr_sts  = i_wr && (i_addr == OFS_MSG_STATUS);
		clr_v   = wr_sts ? i_wdata[FLAG_W-1:0] : '0;
		flags_d = (flags_q & ~clr_v) | set_v;
		// A newly logged first error rewrites the severity, so a stale fatal never lingers
		if (cap_unc) begin
			flags_d[BIT_FIRST_FATAL] = set_v[BIT_FIRST_FATAL];
		end
		en_d    = en_q;
		if (i_wr && (i_addr == OFS_INT_CTRL)) begin
			en_d = i_wdata[EN_W-1:0];
		end
		if (i_por) begin
			flags_d = FLAGS_RST;
			en_d    = EN_RST;
		end
	end

	always_ff @(posedge i_clk) begin
		flags_q <= flags_d;
		en_q    <= en_d;
	end

	// Read path, zero for unmapped offsets
	always_comb begin
		rdata_d = DATA_ZERO;
		if (i_rd) begin
			unique case (i_addr)
				OFS_MSG_STATUS: begin
					rdata_d[MSGNUM_LSB +: MSGNUM_W] = MSG_NUM;
					rdata_d[FLAG_W-1:0]             = flags_q;
				end
				OFS_INT_CTRL: begin
					rdata_d[EN_W-1:0] = en_q;
				end
				OFS_SRC_ID: begin
					rdata_d = src_id;
				end
				default: begin
					rdata_d = DATA_ZERO;
				end
			endcase
		end
		if (!i_rst_n) rdata_d = DATA_ZERO;
	end

	always_ff @(posedge i_clk) begin
		rdata_q <= rdata_d;
	end

	assign o_rdata = rdata_q;

	// Escalation holds while its severity flag stays set, or while BIT_UNC_FIRST is set with BIT_FIRST_FATAL matching the class
	assign o_fatal_esc = flags_q[BIT_FATAL] ||
		(flags_q[BIT_UNC_FIRST] && flags_q[BIT_FIRST_FATAL]);
	assign o_nonfatal_esc = flags_q[BIT_NONFATAL] ||
		(flags_q[BIT_UNC_FIRST] && !flags_q[BIT_FIRST_FATAL]);

	// Requests follow the flags, gated per class
	assign o_irq_fatal    = flags_q[BIT_FATAL] && en_q[EN_FATAL];
	assign o_irq_nonfatal = flags_q[BIT_NONFATAL] && en_q[EN_NONF];
	assign o_irq_cor      = (flags_q[BIT_COR_FIRST] || flags_q[BIT_COR_MULTI]) && en_q[EN_COR];
endmodule // rpems_top
`default_nettype wire

// ===== dv/rpems_checker.sv
// Purpose: Port assertions for the error status bank
// Assumes: Flags are seen through escalation, irq and read ports
// Notes:   Bound into the top module
`timescale 1ns/100ps
`default_nettype none
module rpems_checker #(
	parameter logic [4:0] MSG_NUM = 5'h00
) (
	// Clock, resets, register port
	input wire logic                         i_clk, i_rst_n, i_por, i_wr, i_rd,
	input wire logic [rpems_pkg::ADDR_W-1:0] i_addr,
	input wire logic [rpems_pkg::DATA_W-1:0] o_rdata,
	// Events and outputs
	input wire logic                         i_lnk_vld, i_int_vld, o_fatal_esc,
	input wire rpems_pkg::rpems_sev_t        i_lnk_sev, i_int_sev,
	input wire logic                         o_nonfatal_esc, o_irq_fatal, o_irq_nonfatal
);
	import rpems_pkg::*;
	logic fat_ev;
	logic nonf_ev;
	logic st_rd_q;
	assign fat_ev = (i_lnk_vld && i_lnk_sev == RPEMS_SEV_FATAL)
		|| (i_int_vld && i_int_sev == RPEMS_SEV_FATAL);
	assign nonf_ev = (i_lnk_vld && i_lnk_sev == RPEMS_SEV_NONFATAL)
		|| (i_int_vld && i_int_sev == RPEMS_SEV_NONFATAL);
	// Reads issued in reset return zero, so they are left out
	always_ff @(posedge i_clk) st_rd_q <= i_rd && i_rst_n && i_addr == OFS_MSG_STATUS;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n || i_por);
	chk_msgnum_field: assert property (st_rd_q |-> o_rdata[31:27] == MSG_NUM)
		else $error("message number field wrong");
	chk_reserved_zero: assert property (st_rd_q |-> o_rdata[26:7] == 20'h0_0000)
		else $error("reserved bits not zero");
	chk_fatal_set: assert property (fat_ev |=> o_fatal_esc)
		else $error("fatal event missed");
	chk_nonfatal_set: assert property (nonf_ev |=> o_nonfatal_esc)
		else $error("nonfatal event missed");
	chk_esc_cause: assert property ($rose(o_fatal_esc) |-> $past(fat_ev))
		else $error("fatal escalation without cause");
	// Core reset must not clear it, so only power-up disables this one
	chk_esc_sticky: assert property (disable iff (i_por)
		o_fatal_esc && !i_wr |=> o_fatal_esc) else $error("fatal escalation lost");
	chk_irq_fatal_gate: assert property (o_irq_fatal |-> o_fatal_esc)
		else $error("fatal irq without flag");
	chk_irq_nonf_gate: assert property (o_irq_nonfatal |-> o_nonfatal_esc)
		else $error("nonfatal irq without flag");
endmodule // rpems_checker
bind rpems_top rpems_checker #(.MSG_NUM(MSG_NUM)) u_chk (.*);
`default_nettype wire

// ===== dv/rpems_partner.sv
// Purpose: Sender of error messages on the far side
// Assumes: One message per call
// Notes:   ID lines carry junk between messages
`timescale 1ns/100ps
`default_nettype none
module rpems_partner (
	// Clock and message lines
	input  wire logic                   i_clk,
	output logic                        o_vld = 1'b0,
	output rpems_pkg::rpems_sev_t       o_sev = rpems_pkg::RPEMS_SEV_NONE,
	output logic [rpems_pkg::RID_W-1:0] o_rid = 16'h0000
);
	import rpems_pkg::*;
	task automatic send(input rpems_sev_t sev, input logic [RID_W-1:0] rid);
		@(posedge i_clk);
		o_vld <= 1'b1;
		o_sev <= sev;
		o_rid <= rid;
		@(posedge i_clk);
		o_vld <= 1'b0;
		o_sev <= RPEMS_SEV_NONE;
		o_rid <= ~rid;
	endtask
endmodule // rpems_partner
`default_nettype wire

// ===== dv/rpems_top_test.sv
// Purpose: Self-checking bench for the error status bank
// Assumes: Message number parameter set to 5'h15
// Notes:   Internal errors reuse the sender model
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin n_mismatch++; \
	$display("mismatch %s expected %h seen %h", nm, ex, got); end end
module rpems_top_test;
	import rpems_pkg::*;
	localparam logic [31:0] MF = 32'hA800_0000;
	localparam logic [11:0] ST = OFS_MSG_STATUS;
	logic              i_clk = 1'b0, i_rst_n = 1'b0, i_por = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
	logic [ADDR_W-1:0] i_addr = 12'h000;
	logic [DATA_W-1:0] i_wdata = 32'h0000_0000, o_rdata;
	logic [RID_W-1:0]  i_lnk_rid, i_int_rid;
	logic              i_lnk_vld, i_int_vld, o_fatal_esc, o_nonfatal_esc;
	logic              o_irq_fatal, o_irq_nonfatal, o_irq_cor;
	rpems_sev_t        i_lnk_sev, i_int_sev;
	int n_mismatch = 0;
	int total_checks = 0;
	rpems_top #(.MSG_NUM(5'h15)) dut (.*);
	rpems_partner u_lnk (.i_clk(i_clk), .o_vld(i_lnk_vld), .o_sev(i_lnk_sev), .o_rid(i_lnk_rid));
	rpems_partner u_int (.i_clk(i_clk), .o_vld(i_int_vld), .o_sev(i_int_sev), .o_rid(i_int_rid));
	initial begin
		forever #50 i_clk = ~i_clk;
	end
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] ex);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(negedge i_clk);
		`CHK("rdata", ex, o_rdata)
	endtask
	task automatic outs(input logic [4:0] ex);
		@(negedge i_clk);
		`CHK("outputs", ex, {o_fatal_esc, o_nonfatal_esc, o_irq_fatal, o_irq_nonfatal, o_irq_cor})
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		#500_000;
		n_mismatch++;
		give_verdict();
	end
	initial begin
		repeat (8) @(posedge i_clk);
		i_rst_n <= 1'b1;
		i_por <= 1'b0;
		rd(ST, MF);
		rd(12'h200, 32'h0000_0000);
		u_lnk.send(RPEMS_SEV_COR, 16'h1234);
		rd(ST, MF | 32'h0000_0001);
		u_lnk.send(RPEMS_SEV_COR, 16'h5678);
		rd(ST, MF | 32'h0000_0003);
		wr(ST, 32'hFFFF_FF80);
		rd(ST, MF | 32'h0000_0003);
		wr(ST, 32'h0000_0003);
		rd(ST, MF);
		$display("test correctable done");
		fork
			u_lnk.send(RPEMS_SEV_FATAL, 16'hAAAA);
			u_int.send(RPEMS_SEV_NONFATAL, 16'hBBBB);
		join
		rd(ST, MF | 32'h0000_0074);
		rd(OFS_SRC_ID, 32'hAAAA_1234);
		fork
			u_lnk.send(RPEMS_SEV_COR, 16'h4321);
			u_int.send(RPEMS_SEV_COR, 16'h9999);
		join
		rd(ST, MF | 32'h0000_0075);
		rd(OFS_SRC_ID, 32'hAAAA_4321);
		for (int i = 0; i < 3; i++) begin
			wr(OFS_INT_CTRL, 32'(1 << i));
			outs({2'b11, 3'(1 << i)});
		end
		$display("test same clock done");
		@(posedge i_clk);
		i_rst_n <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_rst_n <= 1'b1;
		rd(ST, MF | 32'h0000_0075);
		rd(OFS_INT_CTRL, 32'h0000_0004);
		$display("test sticky done");
		u_lnk.send(RPEMS_SEV_NONFATAL, 16'h1111);
		rd(ST, MF | 32'h0000_007D);
		fork
			wr(ST, 32'h0000_0040);
			u_lnk.send(RPEMS_SEV_FATAL, 16'h2222);
		join
		rd(ST, MF | 32'h0000_007D);
		wr(ST, 32'h0000_007F);
		outs(5'b0_0000);
		u_lnk.send(RPEMS_SEV_NONFATAL, 16'h3333);
		rd(ST, MF | 32'h0000_0024);
		rd(OFS_SRC_ID, 32'h3333_4321);
		outs(5'b0_1000);
		wr(ST, 32'h0000_007F);
		u_lnk.send(RPEMS_SEV_FATAL, 16'h4444);
		rd(ST, MF | 32'h0000_0054);
		wr(ST, 32'h0000_0004);
		u_lnk.send(RPEMS_SEV_NONFATAL, 16'h5555);
		rd(ST, MF | 32'h0000_0064);
		outs(5'b1_1100);
		rd(OFS_SRC_ID, 32'h5555_4321);
		$display("test uncorrectable done");
		give_verdict();
	end
endmodule // rpems_top_test
`default_nettype wire
